/* hdl/usb_irq_top.sv */
// Purpose: usb interrupt enable, error status and combined interrupt
// Assumes: engine event inputs are one-cycle pulses on the system clock
// Notes: register port answers reads one cycle later, never stalls
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"

// Operation
// - enables for stall, attach, resume, idle
// - enables for token done and frame start
// - enable bit 0 is bus reset in device
// - enable bit 0 is detach in host
// - error reaches interrupt only with bit 1
// - error bits hardware set, write one clears
// - bits 31 to 8 read zero
// - stuffing error sets bit 7
// - bad descriptor or buffer address sets bit 6
// - memory overrun, underrun or truncation sets bit 5
// - over 16 idle bit times sets bit 4
// - non-integral data field sets bit 3
// - data crc failure sets bit 2
// - device mode token crc sets bit 1
// - host mode frame end error sets bit 1
// - packet id check failure sets bit 0
// - error flag only from enabled error bits
module usb_irq_top (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // register port
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // general interrupt sources from the engine
    input wire logic I_STALL_EV,
    input wire logic I_ATTACH_EV,
    input wire logic I_RESUME_EV,
    input wire logic I_IDLE_EV,
    input wire logic I_TOKEN_DONE_EV,
    input wire logic I_FRAME_START_EV,
    input wire logic I_BUS_RESET_EV,
    input wire logic I_DETACH_EV,
    // error sources from the engine and its dma
    input wire logic I_STUFF_ERR,
    input wire logic I_MATRIX_ERR,
    input wire logic I_MEM_ERR,
    input wire logic I_FIELD_ERR,
    input wire logic I_CRC16_ERR,
    input wire logic I_CRC5_ERR,
    input wire logic I_SOF_ZERO,
    input wire logic I_XFER_BUSY,
    input wire logic I_PID_ERR,
    input wire logic I_EOP,
    input wire logic I_BUS_ACTIVE,
    // outputs
    output logic O_HOST_MODE,
    output logic O_IRQ
);
    typedef struct packed {
        logic [7:0] irq_enable;
        logic [7:0] err_enable;
        logic host_mode;
        logic [5:0] bit_div;
        logic bit_en;
        logic [31:0] rdata;
        logic irq;
    } state_s;

    state_s state_reg;
    state_s state_next;

    usb_irq_pkg::bus_req_s req;
    usb_irq_pkg::engine_ev_s ev;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [7:0] err_flags;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic [7:0] irq_flags;
    logic turn_timeout;
    logic err_pending;
    logic [7:0] irq_flags_eff;

    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign ev = '{stuff: I_STUFF_ERR, matrix: I_MATRIX_ERR, mem: I_MEM_ERR,
                  field: I_FIELD_ERR, crc16: I_CRC16_ERR, crc5: I_CRC5_ERR,
                  sof_zero: I_SOF_ZERO, xfer_busy: I_XFER_BUSY, pid: I_PID_ERR,
                  eop: I_EOP, bus_active: I_BUS_ACTIVE};

    usb_turnaround_timer u_turn (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_bit_en(state_reg.bit_en),
        .i_eop(ev.eop),
        .i_bus_active(ev.bus_active),
        .o_timeout(turn_timeout)
    );

    // hardware error sets
    always_comb begin
        err_set = 8'h00;
        err_set[`BIT_ERR_STUFF] = ev.stuff;
        err_set[`BIT_ERR_MATRIX] = ev.matrix;
        err_set[`BIT_ERR_MEM] = ev.mem;
        err_set[`BIT_ERR_TURN] = turn_timeout;
        err_set[`BIT_ERR_FIELD] = ev.field;
        err_set[`BIT_ERR_CRC16] = ev.crc16;
        // bit 1 has one meaning per role
        if (state_reg.host_mode) begin
            err_set[`BIT_ERR_CRC5_EOF] = ev.sof_zero & ev.xfer_busy;
        end else begin
            err_set[`BIT_ERR_CRC5_EOF] = ev.crc5;
        end
        err_set[`BIT_ERR_PID] = ev.pid;
    end

    always_comb begin
        err_clr = 8'h00;
        if (req.wr && req.addr == `ADDR_ERR_STATUS) begin
            err_clr = req.wdata[7:0];
        end
    end

    usb_sticky_bits u_err (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(err_set),
        .i_clr(err_clr),
        .o_flags(err_flags)
    );

    // general error flag follows the enabled error bits, not sticky itself
    assign err_pending = |(err_flags & state_reg.err_enable);

    always_comb begin
        irq_set = 8'h00;
        irq_set[`BIT_STALL] = I_STALL_EV;
        irq_set[`BIT_ATTACH] = I_ATTACH_EV;
        irq_set[`BIT_RESUME] = I_RESUME_EV;
        irq_set[`BIT_IDLE] = I_IDLE_EV;
        irq_set[`BIT_TOKEN_DONE] = I_TOKEN_DONE_EV;
        irq_set[`BIT_FRAME_START] = I_FRAME_START_EV;
        if (state_reg.host_mode) begin
            irq_set[`BIT_RESET_DETACH] = I_DETACH_EV;
        end else begin
            irq_set[`BIT_RESET_DETACH] = I_BUS_RESET_EV;
        end
    end

    always_comb begin
        irq_clr = 8'h00;
        if (req.wr && req.addr == `ADDR_IRQ_FLAGS) begin
            irq_clr = req.wdata[7:0];
        end
        irq_clr[`BIT_ERROR] = 1'b0;
    end

    usb_sticky_bits u_irq (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(irq_set),
        .i_clr(irq_clr),
        .o_flags(irq_flags)
    );

    always_comb begin
        irq_flags_eff = irq_flags;
        irq_flags_eff[`BIT_ERROR] = err_pending;
    end

    always_comb begin
        state_next = state_reg;
        // bit-time enable: 12 Mb/s is not a divisor of 50 MHz; nominal count
        if (state_reg.bit_div == `CLKS_PER_BIT - 6'h01) begin
            state_next.bit_div = 6'h00;
            state_next.bit_en = 1'b1;
        end else begin
            state_next.bit_div = state_reg.bit_div + 6'h01;
            state_next.bit_en = 1'b0;
        end
        if (req.wr) begin
            unique case (req.addr)
                `ADDR_IRQ_ENABLE: begin
                    state_next.irq_enable = req.wdata[7:0];
                end
                `ADDR_ERR_ENABLE: begin
                    state_next.err_enable = req.wdata[7:0];
                end
                `ADDR_CTRL: begin
                    state_next.host_mode = req.wdata[0];
                end
                default: begin
                end
            endcase
        end
        state_next.rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                `ADDR_IRQ_FLAGS: state_next.rdata = {24'h00_0000, irq_flags_eff};
                `ADDR_IRQ_ENABLE: state_next.rdata = {24'h00_0000, state_reg.irq_enable};
                `ADDR_ERR_STATUS: state_next.rdata = {24'h00_0000, err_flags};
                `ADDR_ERR_ENABLE: state_next.rdata = {24'h00_0000, state_reg.err_enable};
                `ADDR_CTRL: state_next.rdata = {31'h0000_0000, state_reg.host_mode};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        // error source gated by bit 1 inside the enable mask
        state_next.irq = |(irq_flags_eff & state_reg.irq_enable);
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_RDATA = state_reg.rdata;
    assign O_HOST_MODE = state_reg.host_mode;
    assign O_IRQ = state_reg.irq;
endmodule

/* include/usb_irq_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: word-indexed register port, 8-bit implemented fields
// Notes: definitions only
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH

`define ADDR_IRQ_FLAGS 4'h0
`define ADDR_IRQ_ENABLE 4'h1
`define ADDR_ERR_STATUS 4'h2
`define ADDR_ERR_ENABLE 4'h3
`define ADDR_CTRL 4'h4

`define BIT_STALL 3'h7
`define BIT_ATTACH 3'h6
`define BIT_RESUME 3'h5
`define BIT_IDLE 3'h4
`define BIT_TOKEN_DONE 3'h3
`define BIT_FRAME_START 3'h2
`define BIT_ERROR 3'h1
`define BIT_RESET_DETACH 3'h0

`define BIT_ERR_STUFF 3'h7
`define BIT_ERR_MATRIX 3'h6
`define BIT_ERR_MEM 3'h5
`define BIT_ERR_TURN 3'h4
`define BIT_ERR_FIELD 3'h3
`define BIT_ERR_CRC16 3'h2
`define BIT_ERR_CRC5_EOF 3'h1
`define BIT_ERR_PID 3'h0

`define RESET_BYTE 8'h00
`define TURNAROUND_BIT_TIMES 5'h10
`define CLKS_PER_BIT 6'h04

`endif

/* include/usb_irq_pkg.sv */
// Purpose: shared types of the usb interrupt block
// Assumes: nothing
// Notes: constants live in usb_irq_cfg.svh
package usb_irq_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic stuff;
        logic matrix;
        logic mem;
        logic field;
        logic crc16;
        logic crc5;
        logic sof_zero;
        logic xfer_busy;
        logic pid;
        logic eop;
        logic bus_active;
    } engine_ev_s;

    typedef enum logic [1:0] {
        TURN_IDLE = 2'b00,
        TURN_WAIT = 2'b01,
        TURN_DONE = 2'b11
    } turn_state_e;

endpackage

/* hdl/usb_sticky_bits.sv */
// Purpose: eight write-one-to-clear sticky flags
// Assumes: set and clear vectors on the system clock
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
module usb_sticky_bits (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // set and clear
    input wire logic [7:0] i_set,
    input wire logic [7:0] i_clr,
    // flags
    output logic [7:0] o_flags
);
    typedef struct packed {
        logic [7:0] flags;
    } state_s;

    state_s state_reg;
    state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.flags = (state_reg.flags & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_flags = state_reg.flags;
endmodule

/* hdl/usb_turnaround_timer.sv */
// Purpose: bus turnaround time-out detector
// Assumes: one-cycle eop pulse, bit-time enable from the top
// Notes: counts idle bit times after end of packet
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"
module usb_turnaround_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // timing
    input wire logic i_bit_en,
    // bus events
    input wire logic i_eop,
    input wire logic i_bus_active,
    // result
    output logic o_timeout
);
    typedef struct packed {
        usb_irq_pkg::turn_state_e st;
        logic [4:0] cnt;
        logic timeout;
    } state_s;

    state_s state_reg;
    state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.timeout = 1'b0;
        unique case (state_reg.st)
            usb_irq_pkg::TURN_IDLE: begin
                if (i_eop) begin
                    state_next.st = usb_irq_pkg::TURN_WAIT;
                    state_next.cnt = 5'h00;
                end
            end
            usb_irq_pkg::TURN_WAIT: begin
                if (i_bus_active) begin
                    state_next.st = usb_irq_pkg::TURN_IDLE;
                end else if (i_bit_en) begin
                    // more than 16 idle bit times: fire on the 17th
                    if (state_reg.cnt == `TURNAROUND_BIT_TIMES) begin
                        state_next.timeout = 1'b1;
                        state_next.st = usb_irq_pkg::TURN_DONE;
                    end else begin
                        state_next.cnt = state_reg.cnt + 5'h01;
                    end
                end
            end
            usb_irq_pkg::TURN_DONE: begin
                state_next.st = usb_irq_pkg::TURN_IDLE;
            end
            default: begin
                state_next.st = usb_irq_pkg::TURN_IDLE;
            end
        endcase
        if (i_eop) begin
            state_next.st = usb_irq_pkg::TURN_WAIT;
            state_next.cnt = 5'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_timeout = state_reg.timeout;
endmodule

/* bench/usb_irq_monitor.sv */
// Purpose: port checks of the usb interrupt block
// Assumes: bound to usb_irq_top
// Notes: error flags judged by a read one quiet cycle after the event
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"
module usb_irq_monitor (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // register port
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    // error sources
    input wire logic I_STUFF_ERR,
    input wire logic I_MATRIX_ERR,
    input wire logic I_MEM_ERR,
    input wire logic I_FIELD_ERR,
    input wire logic I_CRC16_ERR,
    input wire logic I_CRC5_ERR,
    input wire logic I_SOF_ZERO,
    input wire logic I_XFER_BUSY,
    input wire logic I_PID_ERR,
    // outputs
    input wire logic O_HOST_MODE,
    input wire logic O_IRQ
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    sequence s_rde;
        I_RD && I_ADDR == `ADDR_ERR_STATUS;
    endsequence
    // the gap cycle must carry no write, or a clear could land there
    property p_err(ev, int b);
        ev ##1 !I_WR ##1 s_rde |=> O_RDATA[b];
    endproperty
    chk_stuff_flag: assert property (p_err(I_STUFF_ERR, 7))
        else $error("stuff flag lost");
    chk_matrix_flag: assert property (p_err(I_MATRIX_ERR, 6))
        else $error("matrix flag lost");
    chk_mem_flag: assert property (p_err(I_MEM_ERR, 5))
        else $error("mem flag lost");
    chk_field_flag: assert property (p_err(I_FIELD_ERR, 3))
        else $error("field flag lost");
    chk_crc16_flag: assert property (p_err(I_CRC16_ERR, 2))
        else $error("crc16 flag lost");
    chk_pid_flag: assert property (p_err(I_PID_ERR, 0))
        else $error("pid flag lost");
    chk_crc5_device: assert property (p_err(!O_HOST_MODE && I_CRC5_ERR, 1))
        else $error("token crc flag lost");
    chk_eof_host: assert property (p_err(O_HOST_MODE && I_SOF_ZERO && I_XFER_BUSY, 1))
        else $error("frame end flag lost");
    chk_enable_rw: assert property (I_WR && I_ADDR == `ADDR_IRQ_ENABLE
        ##1 I_RD && I_ADDR == `ADDR_IRQ_ENABLE |=> O_RDATA == ($past(I_WDATA, 2) & 32'hFF))
        else $error("enable readback wrong");
    chk_upper_zero: assert property (O_RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data outside read slot");
    cover property (O_IRQ);
    cover property (O_HOST_MODE && I_SOF_ZERO && I_XFER_BUSY);
    cover property (I_STUFF_ERR ##2 s_rde);
endmodule
bind usb_irq_top usb_irq_monitor u_usb_irq_monitor (.*);

/* bench/usb_engine_model.sv */
// Purpose: protocol engine stand-in driving event lines
// Assumes: tasks entered just after a clock edge
// Notes: bus activity is a level, the rest are pulses
`timescale 1ns/1ns
module usb_engine_model (
    input wire logic i_clk,
    output logic [7:0] o_gen,
    output logic [7:0] o_err,
    output logic o_sof_zero,
    output logic o_xfer_busy,
    output logic o_eop,
    output logic o_bus_active
);
    initial begin
        {o_gen, o_err, o_sof_zero, o_xfer_busy, o_eop} = 19'h0;
        o_bus_active = 1'b1;
    end
    task automatic fire(input logic [7:0] g, input logic [7:0] e, input logic s, input logic b);
        o_gen <= g;
        o_err <= e;
        o_sof_zero <= s;
        o_xfer_busy <= b;
        @(posedge i_clk);
        {o_gen, o_err, o_sof_zero, o_xfer_busy} <= 18'h0;
        @(posedge i_clk);
    endtask
    // idle counted in clocks, bus goes active again after it
    task automatic packet_end(input int idle);
        o_eop <= 1'b1;
        o_bus_active <= 1'b0;
        @(posedge i_clk);
        o_eop <= 1'b0;
        repeat (idle) @(posedge i_clk);
        o_bus_active <= 1'b1;
        @(posedge i_clk);
    endtask
endmodule

/* bench/tb_usb_irq_enable_error_status.sv */
// Purpose: register level test of the usb interrupt block
// Assumes: four clocks per bit time
// Notes: engine events come from usb_engine_model
`timescale 1ns/1ns
`include "usb_irq_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_usb_irq_enable_error_status;
    logic I_CLK_SYS = 0, I_RST = 1, I_WR = 0, I_RD = 0;
    logic [3:0] I_ADDR = 4'h0;
    logic [31:0] I_WDATA = 32'h0;
    wire logic [31:0] O_RDATA;
    wire logic [7:0] gen, err;
    wire logic O_HOST_MODE, O_IRQ, I_SOF_ZERO, I_XFER_BUSY, I_EOP, I_BUS_ACTIVE;
    wire logic I_STALL_EV, I_ATTACH_EV, I_RESUME_EV, I_IDLE_EV, I_TOKEN_DONE_EV;
    wire logic I_FRAME_START_EV, I_BUS_RESET_EV, I_DETACH_EV, I_STUFF_ERR, I_MATRIX_ERR;
    wire logic I_MEM_ERR, I_FIELD_ERR, I_CRC16_ERR, I_CRC5_ERR, I_PID_ERR;
    int error_cnt = 0, check_count = 0;
    assign {I_STALL_EV, I_ATTACH_EV, I_RESUME_EV, I_IDLE_EV, I_TOKEN_DONE_EV,
        I_FRAME_START_EV, I_DETACH_EV, I_BUS_RESET_EV} = gen;
    assign {I_STUFF_ERR, I_MATRIX_ERR, I_MEM_ERR, I_FIELD_ERR, I_CRC16_ERR, I_CRC5_ERR,
        I_PID_ERR} = {err[7:5], err[3:0]};
    usb_irq_top u_usb_irq_top (.*);
    usb_engine_model u_usb_engine_model (.i_clk(I_CLK_SYS), .o_gen(gen), .o_err(err),
        .o_sof_zero(I_SOF_ZERO), .o_xfer_busy(I_XFER_BUSY), .o_eop(I_EOP),
        .o_bus_active(I_BUS_ACTIVE));
    initial forever #10 I_CLK_SYS = ~I_CLK_SYS;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
        @(posedge I_CLK_SYS);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK_SYS);
        I_RD <= 1'b0;
        #1 `CHK("rdata", e, O_RDATA)
        @(posedge I_CLK_SYS);
    endtask
    // write then read with no gap between the strobes
    task automatic wrrd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
        I_RD <= 1'b1;
        @(posedge I_CLK_SYS);
        I_RD <= 1'b0;
        #1 `CHK("rdata", e, O_RDATA)
        @(posedge I_CLK_SYS);
    endtask
    task automatic irqc(input logic e);
        @(posedge I_CLK_SYS);
        #1 `CHK("irq", e, O_IRQ)
    endtask
    task automatic fire(input logic [7:0] g, input logic [7:0] e, input logic s, input logic b);
        u_usb_engine_model.fire(g, e, s, b);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        results;
    end
    initial begin
        repeat (10) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        @(posedge I_CLK_SYS);
        for (int a = 0; a < 5; a++) rdc(a[3:0], 32'h0);
        wr(4'hF, 32'hFF);
        rdc(4'hF, 32'h0);
        wr(`ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
        rdc(`ADDR_IRQ_ENABLE, 32'h0000_00FF);
        wrrd(`ADDR_IRQ_ENABLE, 32'h1234_565A, 32'h0000_005A);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        $display("test registers done");
        for (int i = 7; i >= 2; i--) begin
            fire(8'h01 << i, 8'h00, 1'b0, 1'b0);
            rdc(`ADDR_IRQ_FLAGS, 32'h1 << i);
            irqc(1'b0);
            wr(`ADDR_IRQ_ENABLE, 32'h1 << i);
            irqc(1'b1);
            wr(`ADDR_IRQ_FLAGS, 32'h1 << i);
            irqc(1'b0);
        end
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        for (int m = 0; m < 2; m++) begin
            wr(`ADDR_CTRL, m);
            `CHK("host_mode", m[0], O_HOST_MODE)
            fire(m ? 8'h01 : 8'h02, 8'h00, 1'b0, 1'b0);
            rdc(`ADDR_IRQ_FLAGS, 32'h0);
            fire(m ? 8'h02 : 8'h01, 8'h00, 1'b0, 1'b0);
            irqc(1'b1);
            wr(`ADDR_IRQ_FLAGS, 32'h1);
        end
        wr(`ADDR_CTRL, 32'h0);
        $display("test interrupt sources done");
        for (int i = 7; i >= 0; i--) if (i != 4 && i != 1) begin
            fire(8'h00, 8'h01 << i, 1'b0, 1'b0);
            rdc(`ADDR_ERR_STATUS, 32'h1 << i);
            wr(`ADDR_ERR_STATUS, ~(32'h1 << i));
            rdc(`ADDR_ERR_STATUS, 32'h1 << i);
            wr(`ADDR_ERR_STATUS, 32'h1 << i);
            rdc(`ADDR_ERR_STATUS, 32'h0);
        end
        fire(8'h00, 8'h02, 1'b0, 1'b0);
        rdc(`ADDR_ERR_STATUS, 32'h2);
        wr(`ADDR_ERR_STATUS, 32'h2);
        fire(8'h00, 8'h00, 1'b1, 1'b1);
        rdc(`ADDR_ERR_STATUS, 32'h0);
        wr(`ADDR_CTRL, 32'h1);
        fire(8'h00, 8'h02, 1'b1, 1'b0);
        rdc(`ADDR_ERR_STATUS, 32'h0);
        fire(8'h00, 8'h00, 1'b1, 1'b1);
        rdc(`ADDR_ERR_STATUS, 32'h2);
        wr(`ADDR_ERR_STATUS, 32'h2);
        wr(`ADDR_CTRL, 32'h0);
        u_usb_engine_model.packet_end(40);
        rdc(`ADDR_ERR_STATUS, 32'h0);
        u_usb_engine_model.packet_end(100);
        rdc(`ADDR_ERR_STATUS, 32'h10);
        $display("test error flags done");
        wr(`ADDR_ERR_ENABLE, 32'h10);
        rdc(`ADDR_IRQ_FLAGS, 32'h2);
        wr(`ADDR_IRQ_ENABLE, 32'h2);
        irqc(1'b1);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        irqc(1'b0);
        wr(`ADDR_ERR_ENABLE, 32'h80);
        rdc(`ADDR_IRQ_FLAGS, 32'h0);
        $display("test error interrupt done");
        results;
    end
endmodule
